// ===== design/oadc_pkg.sv
package oadc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned N_CHAN  = 8;
  localparam int unsigned WORD_W  = 12;
  localparam int unsigned CONV_W  = N_CHAN * WORD_W;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned N_SYNC  = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CHAN_PD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CUSTOM  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0C;

  // ctrl fields
  localparam int unsigned CTRL_MSB_FIRST_BIT = 0;
  localparam int unsigned CTRL_DESKEW_BIT    = 1;
  localparam int unsigned CTRL_SYNC_BIT      = 2;
  localparam int unsigned CTRL_CUSTOM_BIT    = 3;
  localparam int unsigned CTRL_MON_DIS_BIT   = 4;
  localparam int unsigned CTRL_DRIVE_LSB     = 8;

  // status fields
  localparam int unsigned STAT_PIN_PD_BIT   = 0;
  localparam int unsigned STAT_STOPPED_BIT  = 1;
  localparam int unsigned STAT_PD_ALL_BIT   = 2;
  localparam int unsigned STAT_OVERRUN_BIT  = 3;
  localparam int unsigned STAT_EMPTY_BIT    = 4;
  localparam int unsigned STAT_FULL_BIT     = 5;

  // reset values
  localparam logic [7:0]        CHAN_PD_RST = 8'h00;
  localparam logic [WORD_W-1:0] CUSTOM_RST  = 12'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {DRV_3P5MA, DRV_2P5MA, DRV_4P5MA, DRV_1P75MA} oadc_drive_e;
  typedef enum logic {ST_OFF, ST_RUN} oadc_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned PCLK_FREQ_KHZ    = 20000;
  localparam int unsigned MON_MIN_FREQ_KHZ = 3000;
  localparam logic [3:0]  MON_LIMIT_CYC    = 4'(PCLK_FREQ_KHZ / MON_MIN_FREQ_KHZ);
  localparam int unsigned LATENCY_HALF_CYC = 13;
  localparam int unsigned DELAY_DEPTH      = LATENCY_HALF_CYC / 2 + 1;
  localparam int unsigned FIFO_DEPTH       = 4;
  localparam logic [3:0]  WORD_LAST_BIT    = 4'hB;
  localparam logic [3:0]  SYNC_ZERO_BITS   = 4'h6;
  localparam logic [3:0]  FRAME_HIGH_BITS  = 4'h6;

endpackage

// ===== design/oadc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module oadc_fifo #(
  parameter int unsigned WIDTH = 96,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } oadc_fifo_s;

  oadc_fifo_s fifo_r;
  oadc_fifo_s fifo_nxt;
  logic       push;
  logic       pop;

  assign in_ready  = (fifo_r.cnt != (PW+1)'(DEPTH));
  assign out_valid = (fifo_r.cnt != '0);
  assign out_data  = fifo_r.mem[fifo_r.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    fifo_nxt = fifo_r;
    if (push)
    begin
      fifo_nxt.mem[fifo_r.wr] = in_data;
      fifo_nxt.wr             = fifo_r.wr + 1'b1;
    end
    if (pop)
      fifo_nxt.rd = fifo_r.rd + 1'b1;
    if (push && !pop)
      fifo_nxt.cnt = fifo_r.cnt + 1'b1;
    else if (pop && !push)
      fifo_nxt.cnt = fifo_r.cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fifo_r <= '0;
    else
      fifo_r <= fifo_nxt;
  end
endmodule
`default_nettype wire

// ===== design/oadc_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
module oadc_delay_line #(
  parameter int unsigned WIDTH = 96,
  parameter int unsigned DEPTH = 7
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             shift,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } oadc_dly_s;

  oadc_dly_s dly_r;
  oadc_dly_s dly_nxt;

  assign dout = dly_r.stage[DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    dly_nxt = dly_r;
    if (shift)
    begin
      dly_nxt.stage[0] = din;
      for (int k = 1; k < DEPTH; k++)
        dly_nxt.stage[k] = dly_r.stage[k-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dly_r <= '0;
    else
      dly_r <= dly_nxt;
  end
endmodule
`default_nettype wire

// ===== design/oadc_serial_out.sv
// Contract
// - words go out lsb first by default; a control bit selects msb first
// - frame clock output marks the first bit of every 12-bit word
// - bit clock at six times the frame rate, aligned with the serial data
// - serializer shifts all twelve bits of a word within one frame period
// - deskew setting replaces data with alternating zero-one bits
// - sync setting sends six zeros then six ones, aligned to frame clock
// - a user-defined custom pattern can replace conversion data
// - four drive current settings, 3.5mA after reset
// - power-down pin high powers down references, clocks and all channels
// - each channel can be powered down alone by register
// - stopped or below-3MHz sample clock forces power-down
// - a control bit disables the stopped-clock monitor
// - reset pulse clears every configuration register to zero
// - sample appears at serializer 6.5 sample clock cycles after sampling
`timescale 1ns/1ps
`default_nettype none
module oadc_serial_out (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [oadc_pkg::ADDR_W-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [oadc_pkg::DATA_W-1:0] pwdata,
  output logic                             pready,
  output logic      [oadc_pkg::DATA_W-1:0] prdata,
  output logic                             pslverr,
  input  wire logic                        sample_clock_in,
  input  wire logic                        power_down_pin,
  input  wire logic                        reset_pulse_pin,
  input  wire logic [oadc_pkg::CONV_W-1:0] conv_data,
  output logic      [oadc_pkg::N_CHAN-1:0] data_out_pos,
  output logic      [oadc_pkg::N_CHAN-1:0] data_out_neg,
  output logic                             bit_clock_out_pos,
  output logic                             bit_clock_out_neg,
  output logic                             frame_clock_out_pos,
  output logic                             frame_clock_out_neg,
  output logic      [1:0]                  drive_sel,
  output logic                             ref_power_down,
  output logic                             clk_power_down,
  output logic      [oadc_pkg::N_CHAN-1:0] chan_power_down
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [oadc_pkg::N_SYNC-1:0] meta;
    logic [oadc_pkg::N_SYNC-1:0] sync;
    logic                        sclk_prev;
    logic [3:0]                  mon_cnt;
    logic                        stopped;
    logic                        msb_first;
    logic                        deskew;
    logic                        sync_en;
    logic                        custom_en;
    logic                        mon_dis;
    oadc_pkg::oadc_drive_e       drive;
    logic [oadc_pkg::N_CHAN-1:0] chan_pd;
    logic [oadc_pkg::WORD_W-1:0] custom;
    logic                        overrun;
    logic [oadc_pkg::DATA_W-1:0] rdata;
    logic                        slverr;
    oadc_pkg::oadc_state_e       st;
    logic [3:0]                  bit_cnt;
    logic [oadc_pkg::CONV_W-1:0] word;
    logic [oadc_pkg::N_CHAN-1:0] dout;
    logic                        bclk;
    logic                        fclk;
    logic                        active;
  } oadc_ctl_s;

  oadc_ctl_s                   ctl_r;
  oadc_ctl_s                   ctl_nxt;
  logic                        sclk_rise;
  logic                        sclk_fall;
  logic                        pin_pd;
  logic                        reset_pin;
  logic                        pd_all;
  logic                        apb_setup;
  logic                        apb_write;
  logic                        fifo_in_valid;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  logic [oadc_pkg::CONV_W-1:0] fifo_out_data;
  logic [oadc_pkg::CONV_W-1:0] masked_conv;
  logic [oadc_pkg::CONV_W-1:0] delayed_conv;
  logic [oadc_pkg::N_CHAN-1:0] ser_bit;
  logic [3:0]                  bit_idx;
  logic [oadc_pkg::CONV_W-1:0] next_word;
  logic [oadc_pkg::DATA_W-1:0] status_word;

  ////////////////////////////////////////////////////////////////////////////////
  // pin edges and power-down decision
  assign sclk_rise = ctl_r.sync[0] & ~ctl_r.sclk_prev;
  assign sclk_fall = ~ctl_r.sync[0] & ctl_r.sclk_prev;
  assign pin_pd    = ctl_r.sync[1];
  assign reset_pin = ctl_r.sync[2];
  assign pd_all    = pin_pd | (ctl_r.stopped & ~ctl_r.mon_dis);

  ////////////////////////////////////////////////////////////////////////////////
  // latency line and word buffer
  oadc_delay_line #(
    .WIDTH (oadc_pkg::CONV_W),
    .DEPTH (oadc_pkg::DELAY_DEPTH)
  ) u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .shift   (sclk_rise),
    .din     (masked_conv),
    .dout    (delayed_conv)
  );

  // pushed on the falling edge after the seventh stage fills
  assign fifo_in_valid  = sclk_fall & ~pd_all;
  assign fifo_out_ready = ~pd_all &
                          ((ctl_r.st == oadc_pkg::ST_OFF) ||
                           (ctl_r.bit_cnt == oadc_pkg::WORD_LAST_BIT));
  assign next_word      = fifo_out_valid ? fifo_out_data : '0;

  oadc_fifo #(
    .WIDTH (oadc_pkg::CONV_W),
    .DEPTH (oadc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (delayed_conv),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel bit select
  assign bit_idx = ctl_r.msb_first ? (oadc_pkg::WORD_LAST_BIT - ctl_r.bit_cnt)
                                   : ctl_r.bit_cnt;

  genvar gi;
  generate
    for (gi = 0; gi < oadc_pkg::N_CHAN; gi++)
    begin : g_chan
      assign masked_conv[gi*oadc_pkg::WORD_W +: oadc_pkg::WORD_W] =
        ctl_r.chan_pd[gi] ? '0 : conv_data[gi*oadc_pkg::WORD_W +: oadc_pkg::WORD_W];
      always_comb
      begin
        if (ctl_r.chan_pd[gi])
          ser_bit[gi] = 1'b0;
        else if (ctl_r.custom_en)
          ser_bit[gi] = ctl_r.custom[bit_idx];
        else if (ctl_r.sync_en)
          ser_bit[gi] = (ctl_r.bit_cnt >= oadc_pkg::SYNC_ZERO_BITS);
        else if (ctl_r.deskew)
          ser_bit[gi] = ctl_r.bit_cnt[0];
        else
          ser_bit[gi] = ctl_r.word[gi*oadc_pkg::WORD_W + int'(bit_idx)];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // status view
  always_comb
  begin
    status_word                                = '0;
    status_word[oadc_pkg::STAT_PIN_PD_BIT]     = pin_pd;
    status_word[oadc_pkg::STAT_STOPPED_BIT]    = ctl_r.stopped;
    status_word[oadc_pkg::STAT_PD_ALL_BIT]     = pd_all;
    status_word[oadc_pkg::STAT_OVERRUN_BIT]    = ctl_r.overrun;
    status_word[oadc_pkg::STAT_EMPTY_BIT]      = ~fifo_out_valid;
    status_word[oadc_pkg::STAT_FULL_BIT]       = ~fifo_in_ready;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign prdata    = ctl_r.rdata;
  assign pslverr   = psel & penable & ctl_r.slverr;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    ctl_nxt           = ctl_r;
    ctl_nxt.meta      = {reset_pulse_pin, power_down_pin, sample_clock_in};
    ctl_nxt.sync      = ctl_r.meta;
    ctl_nxt.sclk_prev = ctl_r.sync[0];

    // stopped-clock monitor
    // an edge that comes too late keeps power-down
    if (sclk_rise)
    begin
      ctl_nxt.mon_cnt = '0;
      ctl_nxt.stopped = (ctl_r.mon_cnt == oadc_pkg::MON_LIMIT_CYC);
    end
    else if (ctl_r.mon_cnt != oadc_pkg::MON_LIMIT_CYC)
      ctl_nxt.mon_cnt = ctl_r.mon_cnt + 1'b1;
    else
      ctl_nxt.stopped = 1'b1;

    // read data prepared in the setup phase
    if (apb_setup)
    begin
      ctl_nxt.slverr = 1'b0;
      ctl_nxt.rdata  = '0;
      if (paddr == oadc_pkg::OFF_CTRL)
      begin
        ctl_nxt.rdata[oadc_pkg::CTRL_MSB_FIRST_BIT] = ctl_r.msb_first;
        ctl_nxt.rdata[oadc_pkg::CTRL_DESKEW_BIT]    = ctl_r.deskew;
        ctl_nxt.rdata[oadc_pkg::CTRL_SYNC_BIT]      = ctl_r.sync_en;
        ctl_nxt.rdata[oadc_pkg::CTRL_CUSTOM_BIT]    = ctl_r.custom_en;
        ctl_nxt.rdata[oadc_pkg::CTRL_MON_DIS_BIT]   = ctl_r.mon_dis;
        ctl_nxt.rdata[oadc_pkg::CTRL_DRIVE_LSB +: 2] = ctl_r.drive;
      end
      else if (paddr == oadc_pkg::OFF_CHAN_PD)
        ctl_nxt.rdata[oadc_pkg::N_CHAN-1:0] = ctl_r.chan_pd;
      else if (paddr == oadc_pkg::OFF_CUSTOM)
        ctl_nxt.rdata[oadc_pkg::WORD_W-1:0] = ctl_r.custom;
      else if (paddr == oadc_pkg::OFF_STATUS)
        ctl_nxt.rdata = status_word;
      else
        ctl_nxt.slverr = 1'b1;
    end

    // register writes
    if (apb_write)
    begin
      if (paddr == oadc_pkg::OFF_CTRL)
      begin
        ctl_nxt.msb_first = pwdata[oadc_pkg::CTRL_MSB_FIRST_BIT];
        ctl_nxt.deskew    = pwdata[oadc_pkg::CTRL_DESKEW_BIT];
        ctl_nxt.sync_en   = pwdata[oadc_pkg::CTRL_SYNC_BIT];
        ctl_nxt.custom_en = pwdata[oadc_pkg::CTRL_CUSTOM_BIT];
        ctl_nxt.mon_dis   = pwdata[oadc_pkg::CTRL_MON_DIS_BIT];
        ctl_nxt.drive     =
          oadc_pkg::oadc_drive_e'(pwdata[oadc_pkg::CTRL_DRIVE_LSB +: 2]);
      end
      else if (paddr == oadc_pkg::OFF_CHAN_PD)
        ctl_nxt.chan_pd = pwdata[oadc_pkg::N_CHAN-1:0];
      else if (paddr == oadc_pkg::OFF_CUSTOM)
        ctl_nxt.custom = pwdata[oadc_pkg::WORD_W-1:0];
      else if (paddr == oadc_pkg::OFF_STATUS)
      begin
        if (pwdata[oadc_pkg::STAT_OVERRUN_BIT])
          ctl_nxt.overrun = 1'b0;
      end
    end

    // lost word: set wins over clear
    if (fifo_in_valid && !fifo_in_ready)
      ctl_nxt.overrun = 1'b1;

    // reset pulse clears configuration
    if (reset_pin)
    begin
      ctl_nxt.msb_first = 1'b0;
      ctl_nxt.deskew    = 1'b0;
      ctl_nxt.sync_en   = 1'b0;
      ctl_nxt.custom_en = 1'b0;
      ctl_nxt.mon_dis   = 1'b0;
      ctl_nxt.drive     = oadc_pkg::DRV_3P5MA;
      ctl_nxt.chan_pd   = oadc_pkg::CHAN_PD_RST;
      ctl_nxt.custom    = oadc_pkg::CUSTOM_RST;
      ctl_nxt.overrun   = 1'b0;
    end

    // serializer
    case (ctl_r.st)
      oadc_pkg::ST_OFF:
      begin
        ctl_nxt.dout   = '0;
        ctl_nxt.bclk   = 1'b0;
        ctl_nxt.fclk   = 1'b0;
        ctl_nxt.active = 1'b0;
        if (!pd_all)
        begin
          ctl_nxt.st      = oadc_pkg::ST_RUN;
          ctl_nxt.bit_cnt = '0;
          ctl_nxt.word    = next_word;
        end
      end
      oadc_pkg::ST_RUN:
      begin
        if (pd_all)
        begin
          ctl_nxt.st     = oadc_pkg::ST_OFF;
          ctl_nxt.dout   = '0;
          ctl_nxt.bclk   = 1'b0;
          ctl_nxt.fclk   = 1'b0;
          ctl_nxt.active = 1'b0;
        end
        else
        begin
          ctl_nxt.active = 1'b1;
          ctl_nxt.dout   = ser_bit;
          ctl_nxt.bclk   = ~ctl_r.bit_cnt[0];
          ctl_nxt.fclk   = (ctl_r.bit_cnt < oadc_pkg::FRAME_HIGH_BITS);
          if (ctl_r.bit_cnt == oadc_pkg::WORD_LAST_BIT)
          begin
            ctl_nxt.bit_cnt = '0;
            ctl_nxt.word    = next_word;
          end
          else
            ctl_nxt.bit_cnt = ctl_r.bit_cnt + 1'b1;
        end
      end
      default:
        ctl_nxt.st = oadc_pkg::ST_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_r <= '0;
    else
      ctl_r <= ctl_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign data_out_pos        = ctl_r.dout;
  assign data_out_neg        = ctl_r.active ? ~ctl_r.dout : '0;
  assign bit_clock_out_pos   = ctl_r.bclk;
  assign bit_clock_out_neg   = ctl_r.active & ~ctl_r.bclk;
  assign frame_clock_out_pos = ctl_r.fclk;
  assign frame_clock_out_neg = ctl_r.active & ~ctl_r.fclk;
  assign drive_sel           = ctl_r.drive;
  assign ref_power_down      = pd_all;
  assign clk_power_down      = pd_all;
  assign chan_power_down     = ctl_r.chan_pd | {oadc_pkg::N_CHAN{pd_all}};

endmodule
`default_nettype wire

// ===== verif/oadc_serial_out_checker.sv
`timescale 1ns/1ps
`default_nettype none
module oadc_serial_out_checker (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        power_down_pin,
  input wire logic                        reset_pulse_pin,
  input wire logic [oadc_pkg::N_CHAN-1:0] data_out_pos,
  input wire logic [oadc_pkg::N_CHAN-1:0] data_out_neg,
  input wire logic                        bit_clock_out_pos,
  input wire logic                        bit_clock_out_neg,
  input wire logic                        frame_clock_out_pos,
  input wire logic                        frame_clock_out_neg,
  input wire logic [1:0]                  drive_sel,
  input wire logic                        ref_power_down,
  input wire logic                        clk_power_down,
  input wire logic [oadc_pkg::N_CHAN-1:0] chan_power_down
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // serializer running
  wire run = bit_clock_out_pos ^ bit_clock_out_neg;

  ////////////////////////////////////////////////////////////////////////////////
  a_pair_invert: assert property (run |-> data_out_neg == ~data_out_pos)
    else $error("data pair not complementary");
  a_bit_toggle: assert property (run && $past(run) |-> $changed(bit_clock_out_pos))
    else $error("bit clock did not toggle");
  a_frame_start: assert property ($rose(frame_clock_out_pos) |-> bit_clock_out_pos
    ##1 (frame_clock_out_pos || !run)[*5] ##1 !frame_clock_out_pos)
    else $error("frame clock high phase wrong");
  a_frame_low: assert property ($fell(frame_clock_out_pos) && run
    |-> (!frame_clock_out_pos)[*6] ##1 (frame_clock_out_pos || !run))
    else $error("frame period not twelve bits");
  a_frame_pair: assert property (run |-> frame_clock_out_neg == !frame_clock_out_pos)
    else $error("frame pair not complementary");
  a_pin_down: assert property (power_down_pin[*5]
    |-> ref_power_down && clk_power_down && chan_power_down == 8'hFF)
    else $error("pin did not power down");
  a_down_quiet: assert property (ref_power_down[*2]
    |-> !run && data_out_pos == 8'h00 && !frame_clock_out_pos)
    else $error("outputs active while powered down");
  a_chan_quiet: assert property (
    (chan_power_down & $past(chan_power_down) & data_out_pos) == 8'h00)
    else $error("powered down channel drives data");
  a_pulse_clears: assert property (reset_pulse_pin[*6] |-> drive_sel == 2'h0)
    else $error("reset pulse left drive setting");

  c_frame: cover property ($rose(frame_clock_out_pos) ##12 $rose(frame_clock_out_pos));
  c_pin: cover property (power_down_pin ##5 ref_power_down);
  c_chan: cover property (run && chan_power_down != 8'h00);
endmodule

bind oadc_serial_out oadc_serial_out_checker oadc_serial_out_checker_i (
  .pclk, .presetn, .power_down_pin, .reset_pulse_pin, .data_out_pos, .data_out_neg,
  .bit_clock_out_pos, .bit_clock_out_neg, .frame_clock_out_pos, .frame_clock_out_neg, .drive_sel,
  .ref_power_down, .clk_power_down, .chan_power_down
);
`default_nettype wire

// ===== verif/oadc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module oadc_rx_model (
  input  wire logic                        pclk,
  input  wire logic [oadc_pkg::N_CHAN-1:0] data_in,
  input  wire logic                        bit_clk,
  input  wire logic                        frame_clk,
  output logic      [oadc_pkg::CONV_W-1:0] word,
  output int                               n_words
);
  logic [oadc_pkg::CONV_W-1:0] acc = '0;
  logic [3:0]                  k = 4'h0;
  logic                        bclk_q = 1'b0;
  logic                        fclk_q = 1'b0;

  initial word = '0;
  initial n_words = 0;

  // capture one bit per channel on each bit clock edge
  always @(posedge pclk)
  begin
    if (bit_clk != bclk_q)
    begin
      if (frame_clk && !fclk_q)
        k = 4'h0;
      for (int c = 0; c < 8; c++)
        acc[12 * c + k] = data_in[c];
      if (k == 4'hB)
      begin
        word <= acc;
        n_words <= n_words + 1;
      end
      k = k + 4'h1;
    end
    bclk_q = bit_clk;
    fclk_q = frame_clk;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] MSB = 32'h1 << oadc_pkg::CTRL_MSB_FIRST_BIT;
  localparam logic [31:0] DSK = 32'h1 << oadc_pkg::CTRL_DESKEW_BIT;
  localparam logic [31:0] SYN = 32'h1 << oadc_pkg::CTRL_SYNC_BIT;
  localparam logic [31:0] CUS = 32'h1 << oadc_pkg::CTRL_CUSTOM_BIT;
  localparam logic [31:0] MON = 32'h1 << oadc_pkg::CTRL_MON_DIS_BIT;
  localparam logic [95:0] CONV = 96'hFED_CBA_987_654_321_0FF_A5C_123;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0]  paddr, data_out_pos, data_out_neg, chan_power_down;
  logic [31:0] pwdata, prdata, rd_q;
  logic        sample_clock_in, power_down_pin, reset_pulse_pin, sclk_en;
  logic        bit_clock_out_pos, bit_clock_out_neg, frame_clock_out_pos, frame_clock_out_neg;
  logic        ref_power_down, clk_power_down;
  logic [1:0]  drive_sel;
  logic [95:0] conv_data, rx_word;
  int          rx_n, fail_count, n_tests;
  int          cycles = 0;

  oadc_serial_out oadc_serial_out_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .sample_clock_in, .power_down_pin, .reset_pulse_pin, .conv_data, .data_out_pos,
    .data_out_neg, .bit_clock_out_pos, .bit_clock_out_neg, .frame_clock_out_pos,
    .frame_clock_out_neg, .drive_sel, .ref_power_down, .clk_power_down, .chan_power_down
  );
  oadc_rx_model oadc_rx_model_i (
    .pclk, .data_in(data_out_pos), .bit_clk(bit_clock_out_pos),
    .frame_clk(frame_clock_out_pos), .word(rx_word), .n_words(rx_n)
  );

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // sample clock, own phase, still while disabled
  initial
  begin
    sample_clock_in = 1'b0;
    #13;
    forever #200 sample_clock_in = sclk_en & ~sample_clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [95:0] rev(input logic [95:0] v);
    for (int i = 0; i < 96; i++)
      rev[i] = v[12 * (i / 12) + 11 - i % 12];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic words(input int n);
    int t0;
    t0 = rx_n;
    while (rx_n < t0 + n)
      @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 3; i++)
    begin
      apb(8'(4 * i), 1'b0, 32'h0);
      chk("config reset", 96'h0, 96'(rd_q));
    end
    chk("drive reset", 96'h0, 96'(drive_sel));
  endtask

  task automatic t_unmapped;
    apb(8'h10, 1'b0, 32'h0);
    chk("unmapped read", 96'h1, 96'({rd_q, err_q}));
  endtask

  task automatic t_monitor;
    apb(oadc_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk("stopped clock", 96'h1,
        96'(clk_power_down & rd_q[oadc_pkg::STAT_STOPPED_BIT]));
    apb(oadc_pkg::OFF_CTRL, 1'b1, MON);
    cyc(8'h10);
    chk("monitor off", 96'h0, 96'({ref_power_down, clk_power_down}));
  endtask

  task automatic t_drive;
    for (int i = 0; i < 4; i++)
    begin
      apb(oadc_pkg::OFF_CTRL, 1'b1, MON | (32'(i) << oadc_pkg::CTRL_DRIVE_LSB));
      cyc(8'h03);
      chk("drive select", 96'(i), 96'(drive_sel));
    end
  endtask

  task automatic t_patterns;
    logic [31:0] pc [6];
    logic [11:0] pe [6];
    pc = '{CUS, CUS | MSB, SYN, DSK, SYN | DSK, CUS | SYN};
    pe = '{12'hA5C, 12'h3A5, 12'hFC0, 12'hAAA, 12'hFC0, 12'hA5C};
    apb(oadc_pkg::OFF_CUSTOM, 1'b1, 32'hA5C);
    for (int i = 0; i < 6; i++)
    begin
      apb(oadc_pkg::OFF_CTRL, 1'b1, MON | pc[i]);
      words(3);
      chk("pattern word", {8{pe[i]}}, rx_word);
    end
  endtask

  task automatic t_chanpd;
    apb(oadc_pkg::OFF_CHAN_PD, 1'b1, 32'h81);
    words(3);
    chk("channel down", {12'h0, {6{12'hA5C}}, 12'h0}, rx_word);
    chk("channel pins", 96'h81, 96'(chan_power_down));
    apb(oadc_pkg::OFF_CHAN_PD, 1'b1, 32'h0);
  endtask

  task automatic t_pdpin;
    power_down_pin <= 1'b1;
    cyc(8'h08);
    chk("pin down", 96'h3FF00,
        96'({ref_power_down, clk_power_down, chan_power_down, data_out_pos}));
    power_down_pin <= 1'b0;
    words(2);
    chk("pin release", 96'h0, 96'({ref_power_down, chan_power_down}));
  endtask

  task automatic t_data;
    conv_data <= CONV;
    apb(oadc_pkg::OFF_CTRL, 1'b1, MON);
    sclk_en = 1'b1;
    words(8'h20);
    chk("data lsb first", CONV, rx_word);
    apb(oadc_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk("overrun", 96'h1, 96'(rd_q[oadc_pkg::STAT_OVERRUN_BIT]));
    apb(oadc_pkg::OFF_CTRL, 1'b1, MON | MSB);
    words(8'h04);
    chk("data msb first", rev(CONV), rx_word);
  endtask

  task automatic t_rstpulse;
    int hits;
    hits = 0;
    apb(oadc_pkg::OFF_CTRL, 1'b1, MON | 32'h300);
    reset_pulse_pin <= 1'b1;
    cyc(8'h06);
    reset_pulse_pin <= 1'b0;
    apb(oadc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk("pulse clears", 96'h0, 96'({rd_q, drive_sel}));
    repeat (8'h30)
    begin
      @(posedge pclk);
      hits += int'(clk_power_down === 1'b1);
    end
    chk("slow clock", 96'h30, 96'(hits));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 32'h8000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {power_down_pin, reset_pulse_pin, sclk_en} = 3'h0;
    conv_data = '0;
    fail_count = 0;
    n_tests = 0;
    cyc(8'h10);
    presetn <= 1'b1;
    t_reset;
    t_unmapped;
    t_monitor;
    t_drive;
    t_patterns;
    t_chanpd;
    t_pdpin;
    t_data;
    t_rstpulse;
    tally_and_finish;
  end
endmodule
`default_nettype wire
